//--- testbench.sv
/*
 * self-checking bench for the global configuration bank.
 * assumes tu_pkg values and the bus master model in tu_bus_master.
 */
`timescale 1ns/1ns
`define CHK(nm, got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("unexpected %s exp %h got %h", nm, exp, got); \
		end \
	end
module testbench
	import tu_pkg::*;
;
	localparam logic [19:0] CTRL_EXP = 20'h00001;
	localparam logic [28:0] CFG1_EXP =
		{5'h00, 8'(NUM_SMRG), 8'(NUM_IRPT), 8'(NUM_CB)};

	logic CLK = 1'h0;
	logic RESET = 1'h1;
	logic [7:0] AWADDR, ARADDR, WIDE_VA, CB_SECURE;
	logic [2:0] AWPROT, ARPROT;
	logic [31:0] WDATA, RDATA;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY, SYNC_ACTIVE, HUNG;
	tu_ctrl_s S_CTRL, NS_CTRL;
	tu_cfg1_s CFG1;
	int bad_count = 0;
	int check_count = 0;

	// 25 MHz clock
	always #20 CLK = ~CLK;

	tu_global_cfg u_tu_global_cfg (.CLK(CLK), .RESET(RESET),
		.AWADDR(AWADDR), .AWPROT(AWPROT), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARPROT(ARPROT), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .S_CTRL(S_CTRL), .NS_CTRL(NS_CTRL),
		.CFG1(CFG1), .WIDE_VA(WIDE_VA), .CB_SECURE(CB_SECURE),
		.SYNC_ACTIVE(SYNC_ACTIVE));

	tu_bus_master u_tu_bus_master (.CLK(CLK), .AWADDR(AWADDR),
		.AWPROT(AWPROT), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(ARPROT),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
		.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.HUNG(HUNG));

	task automatic tally_and_finish();
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// a lost bus answer ends the run as a mismatch
	always @(posedge HUNG)
	begin
		bad_count++;
		tally_and_finish();
	end

	task automatic wr_chk(input logic [7:0] a, input logic ns,
		input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		u_tu_bus_master.wr(a, ns, d, r);
		`CHK("bresp", r, er)
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic ns,
		input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		u_tu_bus_master.rd(a, ns, d, r);
		`CHK("rdata", d, ed)
		`CHK("rresp", r, er)
	endtask

	// mid-run reset must restore every defined field
	task automatic do_reset();
		@(posedge CLK);
		RESET <= 1'h1;
		repeat (4) @(posedge CLK);
		RESET <= 1'h0;
	endtask

	task automatic chk_reset();
		@(negedge CLK);
		`CHK("bypass", {S_CTRL[0], NS_CTRL[0]}, 2'h3)
		`CHK("gf_irq", {S_CTRL[1], NS_CTRL[1]}, 2'h0)
		`CHK("gf_abort", {S_CTRL[2], NS_CTRL[2]}, 2'h0)
		`CHK("cf_irq", {S_CTRL[3], NS_CTRL[3]}, 2'h0)
		`CHK("cf_abort", {S_CTRL[4], NS_CTRL[4]}, 2'h0)
		`CHK("stall_en", S_CTRL.global_stall_enable, 1'h0)
		`CHK("memtype", S_CTRL.memtype_override_enable, 1'h0)
		`CHK("share", S_CTRL.shareability_override, 2'h0)
		`CHK("alloc", S_CTRL[15:10], 6'h00)
		`CHK("ext_id", S_CTRL.extended_stream_id_enable, 1'h0)
		`CHK("stall_dis", S_CTRL.stall_disable, 1'h0)
		`CHK("sec_attr", S_CTRL.security_attr_override, 2'h0)
		`CHK("ns_ctrl", NS_CTRL, CTRL_EXP)
		`CHK("sync", SYNC_ACTIVE, 1'h0)
		`CHK("cfg_ro", CFG1.nonsecure_cfg_readonly, 1'h0)
		`CHK("cb_cnt", CFG1.nonsecure_context_count, 8'(NUM_CB))
		`CHK("sec_only", CFG1.global_space_secure_only, 1'h0)
		`CHK("perfmon", CFG1.secure_perfmon_enable, 1'h0)
		`CHK("fetch", CFG1.secure_fetch_restrict, 1'h0)
		`CHK("irq_cnt", CFG1.nonsecure_irq_count, 8'(NUM_IRPT))
		`CHK("wide_va", WIDE_VA, 8'h00)
		`CHK("grp_cnt", CFG1[23:16], 8'(NUM_SMRG))
		rd_chk(OFS_CTRL, 1'h0, 32'(CTRL_EXP), RESP_OKAY);
		rd_chk(OFS_CTRL, 1'h1, 32'(CTRL_EXP), RESP_OKAY);
		rd_chk(OFS_SCFG1, 1'h0, 32'(CFG1_EXP), RESP_OKAY);
		rd_chk(OFS_SYNC, 1'h0, 32'h0, RESP_OKAY);
		rd_chk(OFS_CB_SCHEME, 1'h0, 32'h0, RESP_OKAY);
	endtask

	// move most fields off their reset values; the secure-only flag and the group and context counts keep theirs
	task automatic t_program();
		wr_chk(OFS_CTRL, 1'h0, 32'h000ffffe, RESP_OKAY);
		rd_chk(OFS_CTRL, 1'h0, 32'h000ffffe, RESP_OKAY);
		wr_chk(OFS_CTRL_NS, 1'h0, 32'h000ffffe, RESP_OKAY);
		wr_chk(OFS_SCFG1, 1'h0, 32'h1b100508, RESP_OKAY);
		@(negedge CLK);
		`CHK("cfg_ro_set", CFG1.nonsecure_cfg_readonly, 1'h1)
		`CHK("irq_wr", CFG1.nonsecure_irq_count, 8'h05)
		// read-only control: non-secure write is accepted but dropped
		wr_chk(OFS_CTRL, 1'h1, 32'h0, RESP_OKAY);
		@(negedge CLK);
		`CHK("ns_kept", NS_CTRL, 20'hffffe)
		wr_chk(OFS_CB_SCHEME, 1'h0, 32'hff, RESP_OKAY);
		wr_chk(OFS_CB_SECURITY, 1'h0, 32'h0f, RESP_OKAY);
		@(negedge CLK);
		`CHK("va_lost", WIDE_VA, 8'hf0)
		`CHK("cb_sec", CB_SECURE, 8'h0f)
	endtask

	// secure-only restriction refuses, then lifts
	task automatic t_secure_only();
		wr_chk(OFS_SCFG1, 1'h0, 32'h04100808, RESP_OKAY);
		wr_chk(OFS_CTRL, 1'h1, 32'h1, RESP_SLVERR);
		rd_chk(OFS_CTRL, 1'h1, 32'h0, RESP_SLVERR);
		wr_chk(OFS_SCFG1, 1'h0, 32'h00100808, RESP_OKAY);
		wr_chk(OFS_CTRL, 1'h1, 32'h1, RESP_OKAY);
		@(negedge CLK);
		`CHK("ns_wr", NS_CTRL, 20'h00001)
	endtask

	// sync shows active for a few cycles, then idle again
	task automatic t_sync();
		wr_chk(OFS_SYNC, 1'h0, 32'h0, RESP_OKAY);
		@(negedge CLK);
		`CHK("sync_on", SYNC_ACTIVE, 1'h1)
		rd_chk(OFS_SYNC, 1'h0, 32'h1, RESP_OKAY);
		repeat (6) @(posedge CLK);
		rd_chk(OFS_SYNC, 1'h0, 32'h0, RESP_OKAY);
	endtask

	// unmapped offset refused and reads zero
	task automatic t_unmapped();
		rd_chk(8'h20, 1'h0, 32'h0, RESP_SLVERR);
		wr_chk(8'h20, 1'h0, 32'hffffffff, RESP_SLVERR);
	endtask

	initial
	begin
		repeat (4) @(posedge CLK);
		RESET <= 1'h0;
		chk_reset();
		t_program();
		t_secure_only();
		t_sync();
		t_unmapped();
		do_reset();
		chk_reset();
		tally_and_finish();
	end

endmodule

//--- tu_bus_master.sv
/*
 * register bus master model: one write and one read task.
 * assumes tu_global_cfg answers on the same CLK; HUNG flags a lost answer.
 */
`timescale 1ns/1ns
module tu_bus_master (
	input  wire logic        CLK,     // clock
	output logic [7:0]       AWADDR,  // write address
	output logic [2:0]       AWPROT,  // write protection
	output logic             AWVALID, // write address valid
	input  wire logic        AWREADY, // write address ready
	output logic [31:0]      WDATA,   // write data
	output logic [3:0]       WSTRB,   // write strobes
	output logic             WVALID,  // write data valid
	input  wire logic        WREADY,  // write data ready
	input  wire logic [1:0]  BRESP,   // write response
	input  wire logic        BVALID,  // write response valid
	output logic             BREADY,  // write response ready
	output logic [7:0]       ARADDR,  // read address
	output logic [2:0]       ARPROT,  // read protection
	output logic             ARVALID, // read address valid
	input  wire logic        ARREADY, // read address ready
	input  wire logic [31:0] RDATA,   // read data
	input  wire logic [1:0]  RRESP,   // read response
	input  wire logic        RVALID,  // read valid
	output logic             RREADY,  // read ready
	output logic             HUNG     // an answer never came
);

	// quiet bus at time zero; full word strobes throughout
	initial
	begin
		{AWADDR, AWPROT, AWVALID, WDATA, WVALID, BREADY} = '0;
		{ARADDR, ARPROT, ARVALID, RREADY, HUNG} = '0;
		WSTRB = 4'hf;
	end

	// released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic ns,
		input logic [31:0] d, output logic [1:0] r);
		int n;
		r = 2'hx;
		@(posedge CLK);
		AWADDR  <= a;
		AWPROT  <= {1'h0, ns, 1'h0};
		AWVALID <= 1'h1;
		WDATA   <= d;
		WVALID  <= 1'h1;
		BREADY  <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK);
			if (AWVALID && AWREADY)
			begin
				AWVALID <= 1'h0;
				AWADDR  <= ~a;
			end
			if (WVALID && WREADY)
			begin
				WVALID <= 1'h0;
				WDATA  <= ~d;
			end
			if (BVALID)
			begin
				r = BRESP;
				BREADY <= 1'h0;
				break;
			end
		end
		if (n == 50)
			HUNG <= 1'h1;
	endtask

	// read: address held until taken, rready until the answer
	task automatic rd(input logic [7:0] a, input logic ns,
		output logic [31:0] d, output logic [1:0] r);
		int n;
		d = 32'hx;
		r = 2'hx;
		@(posedge CLK);
		ARADDR  <= a;
		ARPROT  <= {1'h0, ns, 1'h0};
		ARVALID <= 1'h1;
		RREADY  <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge CLK);
			if (ARVALID && ARREADY)
			begin
				ARVALID <= 1'h0;
				ARADDR  <= ~a;
			end
			if (RVALID)
			begin
				d = RDATA;
				r = RRESP;
				RREADY <= 1'h0;
				break;
			end
		end
		if (n == 50)
			HUNG <= 1'h1;
	endtask

endmodule

//--- tu_global_cfg.sv
/*
 * global configuration and status bank of a memory translation unit:
 * secure and non-secure control copies, secure configuration register 1,
 * global invalidate sync status and per-context scheme select.
 * assumes an AXI4-Lite master on CLK; prot bit 1 marks non-secure access.
 */
`timescale 1ns/1ns
module tu_global_cfg
	import tu_pkg::*;
(
	input  wire logic              CLK,         // system clock
	input  wire logic              RESET,       // sync reset, active high
	input  wire logic [7:0]        AWADDR,      // write address
	input  wire logic [2:0]        AWPROT,      // write protection
	input  wire logic              AWVALID,     // write address valid
	output logic                   AWREADY,     // write address ready
	input  wire logic [31:0]       WDATA,       // write data
	input  wire logic [3:0]        WSTRB,       // write byte strobes
	input  wire logic              WVALID,      // write data valid
	output logic                   WREADY,      // write data ready
	output logic [1:0]             BRESP,       // write response
	output logic                   BVALID,      // write response valid
	input  wire logic              BREADY,      // write response ready
	input  wire logic [7:0]        ARADDR,      // read address
	input  wire logic [2:0]        ARPROT,      // read protection
	input  wire logic              ARVALID,     // read address valid
	output logic                   ARREADY,     // read address ready
	output logic [31:0]            RDATA,       // read data
	output logic [1:0]             RRESP,       // read response
	output logic                   RVALID,      // read data valid
	input  wire logic              RREADY,      // read data ready
	output tu_ctrl_s               S_CTRL,      // secure control copy
	output tu_ctrl_s               NS_CTRL,     // non-secure control copy
	output tu_cfg1_s               CFG1,        // secure configuration 1
	output logic [NUM_CB-1:0]      WIDE_VA,     // per-context scheme select
	output logic [NUM_CB-1:0]      CB_SECURE,   // per-context security
	output logic                   SYNC_ACTIVE  // global sync in progress
);

	localparam int SYNC_WAIT = SYNC_CYCLES;

	logic              aw_got;
	logic              w_got;
	logic [7:0]        wr_addr;
	logic              wr_ns;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_do;
	logic              wr_err;
	logic              rd_do;
	logic              rd_err;
	logic [31:0]       rd_word;
	logic              next_aw_got;
	logic              next_w_got;
	logic              next_bvalid;
	logic              next_rvalid;
	logic [SYNC_CNT_W-1:0] sync_cnt;
	logic              sync_start;
	logic [NUM_CB-1:0] sec_flip;
	logic              ctrl_ok;
	logic [31:0]       m_s, m_ns, m_cfg, m_va, m_sec;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (s[i])
				r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction

	// access check: secure-only registers refuse non-secure masters
	function automatic logic refuse(input logic [7:0] a, input logic ns,
		input logic gate);
		logic r;
		r = 1'b1;
		case (a)
			OFS_CTRL, OFS_SYNC, OFS_CB_SCHEME:
				r = ns & gate;
			OFS_CTRL_NS, OFS_SCFG1, OFS_CB_SECURITY:
				r = ns;
			default:
				r = 1'b1;
		endcase
		return r;
	endfunction

	// write path: address and data may come in either order
	assign wr_do  = aw_got && w_got && !BVALID;
	assign wr_err = refuse(wr_addr, wr_ns, CFG1.global_space_secure_only);
	assign rd_do  = ARVALID && ARREADY;
	assign rd_err = refuse({ARADDR[7:2], 2'h0}, ARPROT[PROT_NS_BIT],
		CFG1.global_space_secure_only);
	assign sync_start = wr_do && !wr_err && wr_addr == OFS_SYNC;
	assign ctrl_ok    = wr_do && !wr_err;

	// merged words per target; a call result cannot be part-selected
	assign m_s   = merge(32'(S_CTRL), wr_data, wr_strb);
	assign m_ns  = merge(32'(NS_CTRL), wr_data, wr_strb);
	assign m_cfg = merge(32'(CFG1), wr_data, wr_strb);
	assign m_va  = merge(32'(WIDE_VA), wr_data, wr_strb);
	assign m_sec = merge(32'(CB_SECURE), wr_data, wr_strb);

	// next handshake state, used so that every ready comes from a flop
	always_comb
	begin
		next_aw_got = aw_got;
		next_w_got  = w_got;
		if (AWVALID && AWREADY)
			next_aw_got = 1'b1;
		if (WVALID && WREADY)
			next_w_got = 1'b1;
		if (wr_do)
		begin
			next_aw_got = 1'b0;
			next_w_got  = 1'b0;
		end
		next_bvalid = wr_do || (BVALID && !BREADY);
		next_rvalid = rd_do || (RVALID && !RREADY);
	end

	// write channel holding registers
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			wr_addr <= 8'h00;
			wr_ns   <= 1'b0;
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			BVALID  <= 1'b0;
			BRESP   <= RESP_OKAY;
		end
		else
		begin
			aw_got  <= next_aw_got;
			w_got   <= next_w_got;
			if (AWVALID && AWREADY)
			begin
				wr_addr <= {AWADDR[7:2], 2'h0};
				wr_ns   <= AWPROT[PROT_NS_BIT];
			end
			if (WVALID && WREADY)
			begin
				wr_data <= WDATA;
				wr_strb <= WSTRB;
			end
			// ready drops while a response is pending: one write at a time
			AWREADY <= !next_aw_got && !next_bvalid;
			WREADY  <= !next_w_got && !next_bvalid;
			BVALID  <= next_bvalid;
			if (wr_do)
				BRESP <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end
	end

	// read channel: data is sampled on the address handshake
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0;
			RRESP   <= RESP_OKAY;
		end
		else
		begin
			ARREADY <= !next_rvalid;
			RVALID  <= next_rvalid;
			if (rd_do)
			begin
				RDATA <= rd_err ? 32'h0 : rd_word;
				RRESP <= rd_err ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// read mux; unused upper bits read as zero
	always_comb
	begin
		rd_word = 32'h0;
		case (ARADDR[7:2])
			OFS_CTRL[7:2]:
				rd_word[CTRL_W-1:0] = ARPROT[PROT_NS_BIT] ? NS_CTRL : S_CTRL;
			OFS_CTRL_NS[7:2]:
				rd_word[CTRL_W-1:0] = NS_CTRL;
			OFS_SCFG1[7:2]:
				rd_word[CFG1_W-1:0] = CFG1;
			OFS_SYNC[7:2]:
				rd_word[0] = SYNC_ACTIVE;
			OFS_CB_SCHEME[7:2]:
				rd_word[NUM_CB-1:0] = WIDE_VA;
			OFS_CB_SECURITY[7:2]:
				rd_word[NUM_CB-1:0] = CB_SECURE;
			default:
				rd_word = 32'h0;
		endcase
	end

	// control copies; the plain offset is banked by the access's state
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			S_CTRL  <= CTRL_RESET;
			NS_CTRL <= CTRL_RESET;
		end
		else if (ctrl_ok && wr_addr == OFS_CTRL && !wr_ns)
			S_CTRL <= tu_ctrl_s'(m_s[CTRL_W-1:0]);
		else if (ctrl_ok && (wr_addr == OFS_CTRL_NS ||
			(wr_addr == OFS_CTRL && !CFG1.nonsecure_cfg_readonly)))
			NS_CTRL <= tu_ctrl_s'(m_ns[CTRL_W-1:0]);
	end

	// secure configuration register 1, secure writes only
	always_ff @(posedge CLK)
	begin
		if (RESET)
			CFG1 <= CFG1_RESET;
		else if (ctrl_ok && wr_addr == OFS_SCFG1)
		begin
			CFG1 <= tu_cfg1_s'(m_cfg[CFG1_W-1:0]);
			// hard-wired fields keep their values
			if (!SECURITY_ATTR_OVERRIDE_RO_PROGRAMMABLE)
				CFG1.nonsecure_cfg_readonly <= SECURITY_ATTR_OVERRIDE_RO_FIXED;
			if (!IRQ_COUNT_WRITABLE)
				CFG1.nonsecure_irq_count <= CFG1.nonsecure_irq_count;
		end
	end

	// global invalidate sync: a write starts it, a fixed count ends it
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			SYNC_ACTIVE <= 1'b0;
			sync_cnt    <= '0;
		end
		else if (sync_start)
		begin
			// a new request restarts the wait rather than being lost
			SYNC_ACTIVE <= 1'b1;
			sync_cnt    <= SYNC_CNT_W'(SYNC_CYCLES - 1);
		end
		else if (SYNC_ACTIVE)
		begin
			if (sync_cnt == '0)
				SYNC_ACTIVE <= 1'b0;
			else
				sync_cnt <= sync_cnt - 1'b1;
		end
	end

	// bits of context security that a write would change
	assign sec_flip = (ctrl_ok && wr_addr == OFS_CB_SECURITY) ?
		(m_sec[NUM_CB-1:0] ^ CB_SECURE) : '0;

	// per-context security state
	always_ff @(posedge CLK)
	begin
		if (RESET)
			CB_SECURE <= '0;
		else
			CB_SECURE <= CB_SECURE ^ sec_flip;
	end

	// scheme select; a context changing security loses it, so we
	// force the disabled value there instead of keeping stale state
	always_ff @(posedge CLK)
	begin
		if (RESET)
			WIDE_VA <= {NUM_CB{WIDE_VA_RESET}};
		else if (|sec_flip)
			WIDE_VA <= WIDE_VA & ~sec_flip;
		else if (ctrl_ok && wr_addr == OFS_CB_SCHEME)
			WIDE_VA <= m_va[NUM_CB-1:0];
	end

	// checks on reset state, bus timing and side effects
	property p_bypass_rst;
		@(posedge CLK) RESET |=> S_CTRL.client_disable_bypass &&
			NS_CTRL.client_disable_bypass;
	endproperty
	a_bypass_rst: assert property (p_bypass_rst)
		else $error("client bypass not set after reset");

	property p_fault_en_rst;
		@(posedge CLK) RESET |=> {S_CTRL[4:1], NS_CTRL[4:1]} == 8'h00;
	endproperty
	a_fault_en_rst: assert property (p_fault_en_rst)
		else $error("fault enables not clear after reset");

	property p_override_rst;
		@(posedge CLK) RESET |=> {S_CTRL, NS_CTRL} == {2{20'h00001}};
	endproperty
	a_override_rst: assert property (p_override_rst)
		else $error("override fields not clear after reset");

	property p_cfg1_rst;
		@(posedge CLK) RESET ##1 RESET |-> CFG1 == CFG1_RESET &&
			CFG1.nonsecure_context_count == 8'(NUM_CB) &&
			CFG1.nonsecure_irq_count == 8'(NUM_IRPT);
	endproperty
	a_cfg1_rst: assert property (p_cfg1_rst)
		else $error("secure configuration wrong after reset");

	property p_sync_rst;
		@(posedge CLK) RESET |=> !SYNC_ACTIVE;
	endproperty
	a_sync_rst: assert property (p_sync_rst)
		else $error("sync shown active after reset");

	property p_sync_len;
		@(posedge CLK) disable iff (RESET)
		sync_start ##1 (!sync_start)[*4] |-> ##1 !SYNC_ACTIVE;
	endproperty
	a_sync_len: assert property (p_sync_len)
		else $error("sync did not finish on time");

	property p_sync_hold;
		@(posedge CLK) disable iff (RESET)
		sync_start |=> SYNC_ACTIVE[*4];
	endproperty
	a_sync_hold: assert property (p_sync_hold)
		else $error("sync ended early");

	property p_sec_change;
		@(posedge CLK) disable iff (RESET)
		|sec_flip |=> (WIDE_VA & $past(sec_flip)) == '0 &&
			CB_SECURE != $past(CB_SECURE);
	endproperty
	a_sec_change: assert property (p_sec_change)
		else $error("scheme select kept across security change");

	property p_ns_refused;
		@(posedge CLK) disable iff (RESET)
		wr_do && wr_ns && CFG1.global_space_secure_only &&
			wr_addr == OFS_CTRL |=> BVALID && BRESP == RESP_SLVERR &&
			$stable(NS_CTRL);
	endproperty
	a_ns_refused: assert property (p_ns_refused)
		else $error("non-secure write accepted while secure only");

	property p_rd_time;
		@(posedge CLK) disable iff (RESET)
		rd_do |=> RVALID && (!$past(rd_err) ||
			RDATA == 32'h0 && RRESP == RESP_SLVERR);
	endproperty
	a_rd_time: assert property (p_rd_time)
		else $error("read answer late or refused read not zero");

	c_ns_write: cover property (@(posedge CLK) disable iff (RESET)
		ctrl_ok && wr_addr == OFS_CTRL && wr_ns);
	c_sync_busy: cover property (@(posedge CLK) disable iff (RESET)
		sync_start ##[1:SYNC_WAIT] sync_start);
	c_sec_flip: cover property (@(posedge CLK) disable iff (RESET)
		|sec_flip);
	c_bypass_off: cover property (@(posedge CLK) disable iff (RESET)
		$fell(S_CTRL.client_disable_bypass));

endmodule

//--- tu_pkg.sv
/*
 * constants, field layouts and reset values of the translation unit's
 * global configuration block.
 * assumes a 25 MHz system clock and a 32-bit AXI4-Lite register port.
 */
package tu_pkg;

	// clock and sync timing
	localparam int CLK_NS      = 40;
	localparam int SYNC_NS     = 160;
	localparam int SYNC_CYCLES = (SYNC_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CNT_W  = 3;

	// implemented resources
	localparam int NUM_CB   = 8;
	localparam int NUM_IRPT = 8;
	localparam int NUM_SMRG = 16;

	// implementation choices
	localparam logic STALL_SUPPORTED      = 1'b1;
	localparam logic SECURITY_ATTR_OVERRIDE_RO_PROGRAMMABLE = 1'b1;
	localparam logic SECURITY_ATTR_OVERRIDE_RO_FIXED       = 1'b0;
	localparam logic IRQ_COUNT_WRITABLE   = 1'b1;
	localparam logic WIDE_VA_RESET        = 1'b0;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_CTRL_NS     = 8'h04;
	localparam logic [7:0] OFS_SCFG1       = 8'h08;
	localparam logic [7:0] OFS_SYNC        = 8'h0c;
	localparam logic [7:0] OFS_CB_SCHEME   = 8'h10;
	localparam logic [7:0] OFS_CB_SECURITY = 8'h14;

	// bus answers and protection bit carrying the non-secure flag
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         PROT_NS_BIT = 1;

	// main control register, one copy per security state
	typedef struct packed {
		logic [1:0] security_attr_override;    // [19:18]
		logic       stall_disable;             // [17]
		logic       extended_stream_id_enable; // [16]
		logic [1:0] transient_hint_override;   // [15:14]
		logic [1:0] write_alloc_override;      // [13:12]
		logic [1:0] read_alloc_override;       // [11:10]
		logic [1:0] shareability_override;     // [9:8]
		logic       spare;                     // [7]
		logic       memtype_override_enable;   // [6]
		logic       global_stall_enable;       // [5]
		logic       config_fault_abort_enable; // [4]
		logic       config_fault_irq_enable;   // [3]
		logic       global_fault_abort_enable; // [2]
		logic       global_fault_irq_enable;   // [1]
		logic       client_disable_bypass;     // [0]
	} tu_ctrl_s;

	localparam int CTRL_W = $bits(tu_ctrl_s);

	localparam tu_ctrl_s CTRL_RESET = '{
		security_attr_override:    2'h0,
		stall_disable:             1'h0,
		extended_stream_id_enable: 1'h0,
		transient_hint_override:   2'h0,
		write_alloc_override:      2'h0,
		read_alloc_override:       2'h0,
		shareability_override:     2'h0,
		spare:                     1'h0,
		memtype_override_enable:   1'h0,
		global_stall_enable:       1'h0,
		config_fault_abort_enable: 1'h0,
		config_fault_irq_enable:   1'h0,
		global_fault_abort_enable: 1'h0,
		global_fault_irq_enable:   1'h0,
		client_disable_bypass:     1'h1
	};

	// secure configuration register 1
	typedef struct packed {
		logic       secure_fetch_restrict;       // [28]
		logic       secure_perfmon_enable;       // [27]
		logic       global_space_secure_only;    // [26]
		logic       global_fault_readonly;       // [25]
		logic       nonsecure_cfg_readonly;      // [24]
		logic [7:0] nonsecure_match_group_count; // [23:16]
		logic [7:0] nonsecure_irq_count;         // [15:8]
		logic [7:0] nonsecure_context_count;     // [7:0]
	} tu_cfg1_s;

	localparam int CFG1_W = $bits(tu_cfg1_s);

	localparam tu_cfg1_s CFG1_RESET = '{
		secure_fetch_restrict:       1'h0,
		secure_perfmon_enable:       1'h0,
		global_space_secure_only:    1'h0,
		global_fault_readonly:       1'h0,
		nonsecure_cfg_readonly:      SECURITY_ATTR_OVERRIDE_RO_FIXED,
		nonsecure_match_group_count: 8'(NUM_SMRG),
		nonsecure_irq_count:         8'(NUM_IRPT),
		nonsecure_context_count:     8'(NUM_CB)
	};

endpackage
